// ==== pkg/owdp_consts.svh ====
// Offsets, field positions, reset values and timing counts of the one-wire debug port.
// Assumes a 250 MHz core clock; included by the testbench and the top module.
// Operation
// - Debug traffic runs half-duplex UART over the single reset-pin wire.
// - Physical layer runs on its own port clock, access layer on the core clock.
// - Link-to-access hand-over uses a held request with acknowledge handshake.
// - Enabling or resetting the port starts its clock at 4 MHz.
// - Port clock changes only by debugger write of the divider select field, or back to 4 MHz on break or disable.
// - Baud rate is measured from SYNCH; bits are recovered with that timing.
// - Parity, clock recovery, frame and system errors are detected.
// - Successful stores are answered with an acknowledge character.
// - An error signature records the kind of the last fault.
// - Link layer decodes instruction and data, then starts the access.
// - Access layer reads and writes the system bus.
// - Control and status space is reached without the system bus.
// - Protected addresses need key-unlocked program or stopped debug state.
// - Port is active only by fuse selection or high-voltage enable.
// - Active port drives pull-up, input and output enables of its pin.
// - Software breakpoints plus two hardware breakpoints stop the processor.
// - PC, SP and status register are readable while code runs.
// - Processor break or stop is detected and reported to the debugger.
// - Run, stop and reset debug instructions control program flow.
// - Flash CRC result is readable even on a locked device.
// - Frames: low start, eight data, even parity, two high stops; errors flagged.
// - Low level of twelve bit times is a break, restoring default state.
// - Break resets the clock selection to the 4 MHz default.
`ifndef OWDP_CONSTS_SVH
`define OWDP_CONSTS_SVH
`define OWDP_CORE_CLK_MHZ 250
`define OWDP_DIV_16M (`OWDP_CORE_CLK_MHZ / 16)
`define OWDP_DIV_8M (`OWDP_CORE_CLK_MHZ / 8)
`define OWDP_DIV_4M (`OWDP_CORE_CLK_MHZ / 4)
`define OWDP_CLKSEL_16M 2'h1
`define OWDP_CLKSEL_8M 2'h2
`define OWDP_CLKSEL_4M 2'h3
`define OWDP_BREAK_BITS 5'h0C
`define OWDP_MIN_BIT_TICKS 13'h0002
`define OWDP_ACK_CHAR 8'h40
`define OWDP_OP_LDS 3'h0
`define OWDP_OP_STS 3'h2
`define OWDP_OP_LDCS 3'h4
`define OWDP_OP_STCS 3'h6
`define OWDP_OP_KEY 3'h7
`define OWDP_CS_CTRLA 4'h0
`define OWDP_CS_DBGCTRL 4'h1
`define OWDP_CS_BP0L 4'h2
`define OWDP_CS_BP0H 4'h3
`define OWDP_CS_BP1L 4'h4
`define OWDP_CS_BP1H 4'h5
`define OWDP_CS_BPEN 4'h6
`define OWDP_CS_STATUS 4'h7
`define OWDP_CS_PCL 4'h8
`define OWDP_CS_PCH 4'h9
`define OWDP_CS_SPL 4'hA
`define OWDP_CS_SPH 4'hB
`define OWDP_CS_FLAGS 4'hC
`define OWDP_CS_CRC 4'hD
`define OWDP_DBG_STOP 0
`define OWDP_DBG_RUN 1
`define OWDP_DBG_RESET 2
`define OWDP_ERR_NONE 3'h0
`define OWDP_ERR_PARITY 3'h1
`define OWDP_ERR_FRAME 3'h2
`define OWDP_ERR_CLOCK 3'h3
`define OWDP_ERR_SYSTEM 3'h4
`define OWDP_ERR_DENIED 3'h5
`define OWDP_APB_STATUS 12'h000
`define OWDP_APB_CTRL 12'h004
`define OWDP_APB_CTRL_RESET 32'h00000001
`endif

// ==== pkg/owdp_pkg.sv ====
// Types shared by the one-wire debug port.
// Assumes the constants header is compiled alongside.
package owdp_pkg;
	typedef enum logic [4:0] {
		R_IDLE = 5'h01,
		R_SYNC = 5'h02,
		R_SYNCEND = 5'h04,
		R_START = 5'h08,
		R_BITS = 5'h10
	} owdp_rx_t;
	typedef enum logic [7:0] {
		D_SYNC = 8'h01,
		D_OPC = 8'h02,
		D_AL = 8'h04,
		D_AH = 8'h08,
		D_DATA = 8'h10,
		D_BUS = 8'h20,
		D_TX = 8'h40,
		D_ERR = 8'h80
	} owdp_lk_t;
endpackage

// ==== tb/owdp_checker.sv ====
// Concurrent checks on the one-wire debug port top ports.
// Assumes one core_clk domain and the asynchronous active-low rst_b.
module owdp_checker (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pinOut,
	input wire logic pinOe,
	input wire logic pinPullEn,
	input wire logic pinInEn,
	input wire logic fuseSelect,
	input wire logic hvEnable,
	input wire logic devLocked,
	input wire logic busReq,
	input wire logic busWe,
	input wire logic [15:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busAck
);
	timeunit 1ns;
	timeprecision 1ps;
	logic selSeen_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Sticky, since the high-voltage enable keeps the port selected after it drops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			selSeen_q <= 1'b0;
		end else if (fuseSelect || hvEnable) begin
			selSeen_q <= 1'b1;
		end
	end
	a_pins_paired: assert property (pinPullEn == pinInEn)
		else $error("pull-up and input enables differ");
	a_select_first: assert property (pinInEn |-> selSeen_q)
		else $error("port active without selection");
	a_idle_high: assert property (!pinOe |-> pinOut)
		else $error("released wire value not high");
	a_frame_start: assert property ($rose(pinOe) |-> ##[0:1] !pinOut)
		else $error("frame without low start bit");
	a_frame_stop: assert property ($fell(pinOe) |-> $past(pinOut))
		else $error("frame ended on a low bit");
	a_frame_length: assert property ($rose(pinOe) |-> pinOe [*8])
		else $error("drive window too short");
	a_bus_hold: assert property (busReq && !busAck |=> busReq && $stable(busAddr) &&
		$stable(busWdata) && $stable(busWe))
		else $error("bus request changed before ack");
	a_bus_release: assert property (busReq && busAck |=> !busReq)
		else $error("bus request held after ack");
	a_locked_no_bus: assert property ($rose(busReq) |-> !$past(devLocked))
		else $error("bus access on locked device");
	a_apb_answer: assert property (pready |-> psel && penable && !$past(pready))
		else $error("ready outside a single access cycle");
endmodule

bind owdp_top owdp_checker u_owdp_checker (
	.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
	.pinOut(pinOut), .pinOe(pinOe), .pinPullEn(pinPullEn), .pinInEn(pinInEn),
	.fuseSelect(fuseSelect), .hvEnable(hvEnable), .devLocked(devLocked), .busReq(busReq),
	.busWe(busWe), .busAddr(busAddr), .busWdata(busWdata), .busAck(busAck)
);

// ==== tb/owdp_dbg_model.sv ====
// Debugger on the single wire: sends frames and breaks, receives device frames.
// Assumes the bench resolves the wire with a pull-up; bit time is counted in core cycles.
module owdp_dbg_model #(
	parameter int BIT_CYC = 186
) (
	input wire logic core_clk,
	input wire logic lineLevel,
	output logic dbgDrive,
	output logic dbgBit
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		dbgDrive = 1'b0;
		dbgBit = 1'b1;
	end
	// Second stop bit is left to the pull-up, so the device may answer inside it
	task automatic send_byte(input logic [7:0] b, input logic badPar);
		logic [11:0] f;
		int n;
		f = {2'b11, ^b ^ badPar, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge core_clk);
			dbgDrive <= 1'b1;
			dbgBit <= f[i];
			repeat (BIT_CYC - 1) @(posedge core_clk);
		end
		@(posedge core_clk);
		dbgDrive <= 1'b0;
		n = 0;
		while (lineLevel !== 1'b0 && n < BIT_CYC) begin
			@(posedge core_clk);
			n++;
		end
	endtask
	task automatic send_break();
		@(posedge core_clk);
		dbgDrive <= 1'b1;
		dbgBit <= 1'b0;
		repeat (16 * BIT_CYC) @(posedge core_clk);
		dbgDrive <= 1'b0;
		repeat (3 * BIT_CYC) @(posedge core_clk);
	endtask
	task automatic recv_byte(output logic [7:0] b, output logic ok, input int lim);
		logic [11:0] f;
		int n;
		n = 0;
		while (lineLevel !== 1'b0 && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		b = 8'h00;
		ok = 1'b0;
		if (n >= lim) return;
		repeat (BIT_CYC / 2) @(posedge core_clk);
		for (int i = 0; i < 12; i++) begin
			f[i] = lineLevel;
			if (i < 11) repeat (BIT_CYC) @(posedge core_clk);
		end
		b = f[8:1];
		ok = !f[0] && !(^f[9:1]) && f[10] && f[11];
		repeat (BIT_CYC) @(posedge core_clk);
	endtask
endmodule

// ==== tb/owdp_top_tb.sv ====
// Self-checking bench: APB status, wire instructions, system bus and cpu control.
// Assumes the debugger model on the wire and a one-cycle bus responder here.
`include "owdp_consts.svh"
module owdp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_CYC = 186;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic fuseSelect = 1'b0;
	logic devLocked = 1'b0;
	logic cpuHalted = 1'b0;
	logic busAck = 1'b0;
	logic [7:0] busRdata = 8'h00;
	logic [15:0] cpuPc = 16'h1234;
	logic [7:0] crcStatus = 8'h96;
	logic [31:0] prdata;
	logic pready, pslverr, pinOut, pinOe, pinPullEn, pinInEn, pinIn;
	logic busReq, busWe, cpuStopReq, cpuResetReq, dbgDrive, dbgBit, seenWe;
	logic [15:0] busAddr, seenAddr;
	logic [7:0] busWdata, seenData;
	int err_count = 0;
	int tests_run = 0;
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	// Pull-up holds the released wire; the device enable wins the resolution
	assign pinIn = pinOe ? pinOut : (dbgDrive ? dbgBit : 1'b1);
	always @(posedge core_clk) begin
		busAck <= busReq && !busAck;
		if (busReq && busAck) begin
			seenAddr <= busAddr;
			seenData <= busWdata;
			seenWe <= busWe;
		end
	end
	owdp_top u_owdp_top (
		.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPullEn(pinPullEn), .pinInEn(pinInEn),
		.fuseSelect(fuseSelect), .hvEnable(1'b0), .devLocked(devLocked), .busReq(busReq),
		.busWe(busWe), .busAddr(busAddr), .busWdata(busWdata), .busAck(busAck), .busErr(1'b0),
		.busRdata(busRdata), .cpuPc(cpuPc), .cpuSp(16'h0FF0), .cpuFlags(8'h80),
		.cpuHalted(cpuHalted), .cpuSwBreak(1'b0), .crcStatus(crcStatus),
		.cpuStopReq(cpuStopReq), .cpuResetReq(cpuResetReq)
	);
	owdp_dbg_model #(.BIT_CYC(BIT_CYC)) u_owdp_dbg_model (
		.core_clk(core_clk), .lineLevel(pinIn), .dbgDrive(dbgDrive), .dbgBit(dbgBit)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check(32'(n < 20), 32'h1, "apb answer");
	endtask
	task automatic rd_status(output logic [31:0] d);
		logic e;
		apb(1'b0, `OWDP_APB_STATUS, 32'h0, d, e);
	endtask
	task automatic tx(input logic [7:0] b);
		u_owdp_dbg_model.send_byte(b, 1'b0);
	endtask
	task automatic rx(output logic [8:0] r);
		logic [7:0] b;
		logic ok;
		u_owdp_dbg_model.recv_byte(b, ok, 6 * BIT_CYC);
		r = {ok, b};
	endtask
	task automatic stcs(input logic [3:0] idx, input logic [7:0] d);
		tx(8'h55);
		tx({`OWDP_OP_STCS, 1'b0, idx});
		tx(d);
		repeat (4 * BIT_CYC) @(posedge core_clk);
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic e;
		check(32'({pinOe, pinOut, pinInEn, busReq}), 32'h4, "idle pins");
		rd_status(d);
		check(32'({d[9:7], d[2:0]}), 32'h18, "status after reset");
		apb(1'b0, `OWDP_APB_CTRL, 32'h0, d, e);
		check(d, `OWDP_APB_CTRL_RESET, "ctrl reset");
		apb(1'b1, 12'h010, 32'hFFFFFFFF, d, e);
		check(32'(e), 32'h1, "unmapped write");
		apb(1'b0, 12'h010, 32'h0, d, e);
		check({d[30:0], e}, 32'h1, "unmapped read");
		apb(1'b1, `OWDP_APB_STATUS, 32'hFFFFFFFF, d, e);
		rd_status(d);
		check(32'(d[8:7]), 32'(`OWDP_CLKSEL_4M), "clock select kept");
		fuseSelect <= 1'b1;
		cpuHalted <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd_status(d);
		check(32'({pinPullEn, pinInEn, d[9], d[3]}), 32'hF, "port active");
		cpuHalted <= 1'b0;
	endtask
	task automatic t_bus;
		logic [8:0] r;
		tx(8'h55);
		tx({`OWDP_OP_STS, 5'h00});
		tx(8'h34);
		tx(8'h02);
		tx(8'hA7);
		rx(r);
		check(32'(r), {23'h0, 1'b1, `OWDP_ACK_CHAR}, "store ack");
		check(32'({seenWe, seenAddr, seenData}), 32'h010234A7, "store on bus");
		busRdata <= 8'h3C;
		tx(8'h55);
		tx({`OWDP_OP_LDS, 5'h00});
		tx(8'h56);
		tx(8'h03);
		rx(r);
		check(32'(r), 32'h13C, "load data");
		check(32'({seenWe, seenAddr}), 32'h0356, "load address");
	endtask
	task automatic t_ldcs;
		logic [8:0] r;
		tx(8'h55);
		tx({`OWDP_OP_LDCS, 1'b0, `OWDP_CS_PCL});
		rx(r);
		check(32'(r), 32'h134, "pc low");
		devLocked <= 1'b1;
		tx(8'h55);
		tx({`OWDP_OP_LDCS, 1'b0, `OWDP_CS_CRC});
		rx(r);
		check(32'(r), 32'h196, "crc when locked");
		devLocked <= 1'b0;
	endtask
	task automatic t_flow;
		stcs(`OWDP_CS_DBGCTRL, 8'h01);
		check(32'(cpuStopReq), 32'h1, "stop");
		stcs(`OWDP_CS_DBGCTRL, 8'h04);
		check(32'(cpuResetReq), 32'h1, "reset");
		stcs(`OWDP_CS_DBGCTRL, 8'h02);
		check(32'({cpuStopReq, cpuResetReq}), 32'h0, "run");
	endtask
	task automatic t_errors;
		logic [31:0] d;
		logic [8:0] r;
		stcs(`OWDP_CS_CTRLA, {6'h00, `OWDP_CLKSEL_16M});
		rd_status(d);
		check(32'(d[8:7]), 32'(`OWDP_CLKSEL_16M), "clock select written");
		tx(8'h55);
		u_owdp_dbg_model.send_byte({`OWDP_OP_LDCS, 1'b0, `OWDP_CS_STATUS}, 1'b1);
		rd_status(d);
		check(32'(d[2:0]), 32'(`OWDP_ERR_PARITY), "parity signature");
		tx(8'h55);
		tx({`OWDP_OP_LDCS, 1'b0, `OWDP_CS_STATUS});
		rx(r);
		check(32'(r[8]), 32'h0, "ignored in error");
		u_owdp_dbg_model.send_break();
		rd_status(d);
		check(32'(d[8:7]), 32'(`OWDP_CLKSEL_4M), "break clock select");
		tx(8'h55);
		tx({`OWDP_OP_LDCS, 1'b0, `OWDP_CS_STATUS});
		rx(r);
		check(32'({r[8], r[7]}), 32'h3, "answer after break");
	endtask
	task automatic tally_and_finish;
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		t_reset();
		t_bus();
		t_ldcs();
		t_flow();
		t_errors();
		tally_and_finish();
	end
	// Whole sequence needs about 90000 cycles
	initial begin
		repeat (99000) @(posedge core_clk);
		err_count++;
		$display("wrong value at %0t: run timed out", $time);
		tally_and_finish();
	end
endmodule

// ==== verilog/owdp_top.sv ====
// One-wire program and debug port: physical, link and access layers with APB status.
// Assumes cpu, fuse, crc and system bus signals share core_clk; the pin and hv strobe do not.
//
// Our own choices: the register offsets and the APB interface to the registers.
`include "owdp_consts.svh"
module owdp_top #(
	parameter logic [7:0] KEY_PROG = 8'hA5,
	parameter logic [7:0] KEY_DEBUG = 8'h5A,
	parameter logic [15:0] PROT_BASE = 16'h1000
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe,
	output logic pinPullEn,
	output logic pinInEn,
	input wire logic fuseSelect,
	input wire logic hvEnable,
	input wire logic devLocked,
	output logic busReq,
	output logic busWe,
	output logic [15:0] busAddr,
	output logic [7:0] busWdata,
	input wire logic busAck,
	input wire logic busErr,
	input wire logic [7:0] busRdata,
	input wire logic [15:0] cpuPc,
	input wire logic [15:0] cpuSp,
	input wire logic [7:0] cpuFlags,
	input wire logic cpuHalted,
	input wire logic cpuSwBreak,
	input wire logic [7:0] crcStatus,
	output logic cpuStopReq,
	output logic cpuResetReq
);
	logic rstS1_q, rstS2_q, rst;
	logic pinS1_q, pinS2_q, pinPrev_q, hvS1_q, hvS2_q;
	logic portEnable_q, hvSeen_q, active;
	logic [1:0] clkSel_q;
	logic [5:0] divCnt_q, divLoad;
	logic tick;
	owdp_pkg::owdp_rx_t rxState_q;
	owdp_pkg::owdp_lk_t lkState_q;
	logic [15:0] syncCnt_q;
	logic [2:0] edgeCnt_q;
	logic [12:0] bitTicks_q, rxTimer_q;
	logic [3:0] rxIdx_q;
	logic [10:0] rxShift_q;
	logic rxValid_q, rxErrPar_q, rxErrFrm_q, rxErrClk_q;
	logic [16:0] lowCnt_q, breakLen;
	logic breakHit, fallEdge;
	logic txBusy_q, txStart;
	logic [11:0] txShift_q;
	logic [3:0] txIdx_q;
	logic [12:0] txTimer_q;
	logic [7:0] txByte, respByte_q;
	logic [7:0] opcode_q, dataByte_q;
	logic [15:0] addr_q;
	logic [2:0] errSig_q;
	logic progMode_q, dbgUnlock_q, stopReq_q, resetReq_q, stoppedSeen_q, haltPrev_q;
	logic [15:0] bpAddr_q [2];
	logic [1:0] bpEn_q, bpMatch;
	logic busReq_q, busWe_q;
	logic rdSel, apbStatusSel, apbCtrlSel, apbHit, pready_q, pslverr_q;
	logic [31:0] prdata_q, statusWord;
	logic [7:0] csRead;
	logic protAddr, accessOk, rxOk;
	logic [2:0] op;
	logic [3:0] csIdx;

	function automatic logic [7:0] byteSel(input logic [15:0] w, input logic hi);
		byteSel = hi ? w[15:8] : w[7:0];
	endfunction

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstS1_q <= 1'b0;
			rstS2_q <= 1'b0;
		end else begin
			rstS1_q <= 1'b1;
			rstS2_q <= rstS1_q;
		end
	end
	assign rst = ~rstS2_q;

	// Pin and high-voltage strobe come from outside the clock domain
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pinS1_q <= 1'b1;
			pinS2_q <= 1'b1;
			pinPrev_q <= 1'b1;
			hvS1_q <= 1'b0;
			hvS2_q <= 1'b0;
			hvSeen_q <= 1'b0;
		end else begin
			pinS1_q <= pinIn;
			pinS2_q <= pinS1_q;
			pinPrev_q <= pinS2_q;
			hvS1_q <= hvEnable;
			hvS2_q <= hvS1_q;
			hvSeen_q <= hvSeen_q | hvS2_q;
		end
	end
	assign active = portEnable_q & (fuseSelect | hvSeen_q);
	assign fallEdge = pinPrev_q & ~pinS2_q;

	// Port clock is an enable pulse; the divider follows the selected rate
	assign divLoad = (clkSel_q == `OWDP_CLKSEL_16M) ? 6'(`OWDP_DIV_16M - 1) :
		(clkSel_q == `OWDP_CLKSEL_8M) ? 6'(`OWDP_DIV_8M - 1) : 6'(`OWDP_DIV_4M - 1);
	assign tick = (divCnt_q == 6'h00);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) divCnt_q <= 6'h00;
		else if (!active || tick) divCnt_q <= divLoad;
		else divCnt_q <= divCnt_q - 6'h01;
	end

	// Break: low for twelve bit times, or counter saturation before any baud is known
	assign breakLen = {1'b0, bitTicks_q, 3'h0} + {2'h0, bitTicks_q, 2'h0};
	assign breakHit = tick & ~pinS2_q & ~txBusy_q &
		((lowCnt_q == breakLen && bitTicks_q != 13'h0000) || lowCnt_q == 17'h1FFFF);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) lowCnt_q <= 17'h00000;
		else if (pinS2_q || !active) lowCnt_q <= 17'h00000;
		else if (tick && lowCnt_q != 17'h1FFFF) lowCnt_q <= lowCnt_q + 17'h00001;
	end

	// Receiver: SYNCH measures eight bit times between first and fifth falling edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxState_q <= owdp_pkg::R_IDLE;
			syncCnt_q <= 16'h0000;
			edgeCnt_q <= 3'h0;
			bitTicks_q <= 13'h0000;
			rxTimer_q <= 13'h0000;
			rxIdx_q <= 4'h0;
			rxShift_q <= 11'h000;
			rxValid_q <= 1'b0;
			rxErrPar_q <= 1'b0;
			rxErrFrm_q <= 1'b0;
			rxErrClk_q <= 1'b0;
		end else begin
			rxValid_q <= 1'b0;
			rxErrPar_q <= 1'b0;
			rxErrFrm_q <= 1'b0;
			rxErrClk_q <= 1'b0;
			if (!active || breakHit) begin
				rxState_q <= owdp_pkg::R_IDLE;
			end else begin
				unique case (rxState_q)
					owdp_pkg::R_IDLE: begin
						syncCnt_q <= 16'h0000;
						edgeCnt_q <= 3'h0;
						if (fallEdge && !txBusy_q && lkState_q == owdp_pkg::D_SYNC)
							rxState_q <= owdp_pkg::R_SYNC;
						else if (fallEdge && !txBusy_q && lkState_q != owdp_pkg::D_ERR) begin
							rxState_q <= owdp_pkg::R_START;
							rxTimer_q <= {1'b0, bitTicks_q[12:1]};
						end
					end
					owdp_pkg::R_SYNC: begin
						if (tick && syncCnt_q != 16'hFFFF) syncCnt_q <= syncCnt_q + 16'h0001;
						if (fallEdge) edgeCnt_q <= edgeCnt_q + 3'h1;
						if (fallEdge && edgeCnt_q == 3'h3) begin
							bitTicks_q <= 13'((syncCnt_q + {15'h0000, tick}) >> 3);
							rxErrClk_q <= (syncCnt_q[15:3] < `OWDP_MIN_BIT_TICKS) ||
								(syncCnt_q == 16'hFFFF);
							rxValid_q <= 1'b1;
							rxState_q <= owdp_pkg::R_SYNCEND;
						end
					end
					owdp_pkg::R_SYNCEND: begin
						if (pinS2_q && !pinPrev_q) rxState_q <= owdp_pkg::R_IDLE;
					end
					owdp_pkg::R_START: begin
						if (tick) begin
							rxTimer_q <= rxTimer_q - 13'h0001;
							if (rxTimer_q == 13'h0000) begin
								rxState_q <= pinS2_q ? owdp_pkg::R_IDLE : owdp_pkg::R_BITS;
								rxTimer_q <= bitTicks_q - 13'h0001;
								rxIdx_q <= 4'h0;
							end
						end
					end
					owdp_pkg::R_BITS: begin
						if (tick) begin
							rxTimer_q <= rxTimer_q - 13'h0001;
							if (rxTimer_q == 13'h0000) begin
								rxTimer_q <= bitTicks_q - 13'h0001;
								// Last stop is checked, not stored, so the byte stays in [8:1]
								if (rxIdx_q != 4'hA) rxShift_q <= {pinS2_q, rxShift_q[10:1]};
								rxIdx_q <= rxIdx_q + 4'h1;
								if (rxIdx_q == 4'hA) begin
									rxValid_q <= 1'b1;
									rxErrPar_q <= ^rxShift_q[9:1];
									rxErrFrm_q <= ~pinS2_q | ~rxShift_q[10];
									rxState_q <= owdp_pkg::R_IDLE;
								end
							end
						end
					end
					default: rxState_q <= owdp_pkg::R_IDLE;
				endcase
			end
		end
	end

	// Transmitter: start, eight data, even parity, two stops, at the received baud
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txBusy_q <= 1'b0;
			txShift_q <= 12'hFFF;
			txIdx_q <= 4'h0;
			txTimer_q <= 13'h0000;
		end else if (!active || breakHit) begin
			txBusy_q <= 1'b0;
			txShift_q <= 12'hFFF;
		end else if (txStart) begin
			txBusy_q <= 1'b1;
			txShift_q <= {2'h3, ^txByte, txByte, 1'b0};
			txIdx_q <= 4'h0;
			txTimer_q <= bitTicks_q - 13'h0001;
		end else if (txBusy_q && tick) begin
			txTimer_q <= txTimer_q - 13'h0001;
			if (txTimer_q == 13'h0000) begin
				txTimer_q <= bitTicks_q - 13'h0001;
				txShift_q <= {1'b1, txShift_q[11:1]};
				txIdx_q <= txIdx_q + 4'h1;
				if (txIdx_q == 4'hB) txBusy_q <= 1'b0;
			end
		end
	end

	// Pin drive: release to pulled-up idle outside own frames
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pinOut <= 1'b1;
			pinOe <= 1'b0;
			pinPullEn <= 1'b0;
			pinInEn <= 1'b0;
		end else begin
			pinOut <= txShift_q[0] | ~(active & txBusy_q);
			pinOe <= active & txBusy_q;
			pinPullEn <= active;
			pinInEn <= active;
		end
	end

	// Link layer decode
	assign op = opcode_q[7:5];
	assign csIdx = opcode_q[3:0];
	assign rxOk = rxValid_q & ~rxErrPar_q & ~rxErrFrm_q & ~rxErrClk_q;
	assign protAddr = (addr_q >= PROT_BASE);
	assign accessOk = ~devLocked & (~protAddr | progMode_q | (dbgUnlock_q & cpuHalted));
	generate
		for (genvar i = 0; i < 2; i++) begin : g_bp
			assign bpMatch[i] = bpEn_q[i] & (cpuPc == bpAddr_q[i]);
		end
	endgenerate
	assign statusWord = {22'h0, active, clkSel_q, progMode_q, dbgUnlock_q, stoppedSeen_q, cpuHalted,
		errSig_q};
	assign csRead =
		(csIdx == `OWDP_CS_CTRLA) ? {6'h00, clkSel_q} :
		(csIdx == `OWDP_CS_STATUS) ? statusWord[7:0] :
		(csIdx == `OWDP_CS_PCL || csIdx == `OWDP_CS_PCH) ? byteSel(cpuPc, csIdx[0]) :
		(csIdx == `OWDP_CS_SPL || csIdx == `OWDP_CS_SPH) ? byteSel(cpuSp, csIdx[0]) :
		(csIdx == `OWDP_CS_FLAGS) ? cpuFlags :
		(csIdx == `OWDP_CS_CRC) ? crcStatus : 8'h00;
	assign txStart = (lkState_q == owdp_pkg::D_TX) & ~txBusy_q & ~rdSel;
	assign txByte = respByte_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lkState_q <= owdp_pkg::D_SYNC;
			opcode_q <= 8'h00;
			addr_q <= 16'h0000;
			dataByte_q <= 8'h00;
			respByte_q <= 8'h00;
			rdSel <= 1'b0;
			errSig_q <= `OWDP_ERR_NONE;
			busReq_q <= 1'b0;
			busWe_q <= 1'b0;
		end else if (!active || breakHit) begin
			lkState_q <= owdp_pkg::D_SYNC;
			busReq_q <= 1'b0;
			rdSel <= 1'b0;
		end else begin
			if (rxValid_q && !rxOk)
				errSig_q <= rxErrClk_q ? `OWDP_ERR_CLOCK :
					rxErrPar_q ? `OWDP_ERR_PARITY : `OWDP_ERR_FRAME;
			unique case (lkState_q)
				owdp_pkg::D_SYNC: if (rxValid_q) lkState_q <= rxOk ? owdp_pkg::D_OPC : owdp_pkg::D_ERR;
				owdp_pkg::D_OPC: if (rxValid_q) begin
					opcode_q <= rxShift_q[8:1];
					if (!rxOk) lkState_q <= owdp_pkg::D_ERR;
					else if (rxShift_q[8:6] == `OWDP_OP_LDCS) begin
						rdSel <= 1'b1;
						lkState_q <= owdp_pkg::D_TX;
					end else if (rxShift_q[8:6] == `OWDP_OP_LDS || rxShift_q[8:6] == `OWDP_OP_STS)
						lkState_q <= owdp_pkg::D_AL;
					else lkState_q <= owdp_pkg::D_DATA;
				end
				owdp_pkg::D_AL: if (rxValid_q) begin
					addr_q[7:0] <= rxShift_q[8:1];
					lkState_q <= rxOk ? owdp_pkg::D_AH : owdp_pkg::D_ERR;
				end
				owdp_pkg::D_AH: if (rxValid_q) begin
					addr_q[15:8] <= rxShift_q[8:1];
					lkState_q <= !rxOk ? owdp_pkg::D_ERR :
						(op == `OWDP_OP_LDS) ? owdp_pkg::D_BUS : owdp_pkg::D_DATA;
				end
				owdp_pkg::D_DATA: if (rxValid_q) begin
					dataByte_q <= rxShift_q[8:1];
					lkState_q <= !rxOk ? owdp_pkg::D_ERR :
						(op == `OWDP_OP_STS) ? owdp_pkg::D_BUS : owdp_pkg::D_SYNC;
				end
				owdp_pkg::D_BUS: begin
					if (!busReq_q && !accessOk) begin
						errSig_q <= `OWDP_ERR_DENIED;
						lkState_q <= owdp_pkg::D_ERR;
					end else if (!busReq_q) begin
						busReq_q <= 1'b1;
						busWe_q <= (op == `OWDP_OP_STS);
					end else if (busAck) begin
						busReq_q <= 1'b0;
						respByte_q <= busWe_q ? `OWDP_ACK_CHAR : busRdata;
						if (busErr) begin
							errSig_q <= `OWDP_ERR_SYSTEM;
							lkState_q <= owdp_pkg::D_ERR;
						end else lkState_q <= owdp_pkg::D_TX;
					end
				end
				owdp_pkg::D_TX: begin
					if (rdSel) begin
						respByte_q <= csRead;
						rdSel <= 1'b0;
					end else if (txStart) lkState_q <= owdp_pkg::D_SYNC;
				end
				owdp_pkg::D_ERR: lkState_q <= owdp_pkg::D_ERR;
				default: lkState_q <= owdp_pkg::D_ERR;
			endcase
		end
	end
	assign busReq = busReq_q;
	assign busWe = busWe_q;
	assign busAddr = addr_q;
	assign busWdata = dataByte_q;

	// Control space and debug control, written by the debugger; breakpoints also set the stop request and a cpu halt sets the stopped flag
	wire csWrite = (lkState_q == owdp_pkg::D_DATA) & rxOk & (op == `OWDP_OP_STCS) & active;
	wire keyWrite = (lkState_q == owdp_pkg::D_DATA) & rxOk & (op == `OWDP_OP_KEY) & active;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clkSel_q <= `OWDP_CLKSEL_4M;
			stopReq_q <= 1'b0;
			resetReq_q <= 1'b0;
			bpEn_q <= 2'h0;
			bpAddr_q[0] <= 16'h0000;
			bpAddr_q[1] <= 16'h0000;
			progMode_q <= 1'b0;
			dbgUnlock_q <= 1'b0;
			stoppedSeen_q <= 1'b0;
			haltPrev_q <= 1'b0;
		end else begin
			haltPrev_q <= cpuHalted;
			if (!active || breakHit) clkSel_q <= `OWDP_CLKSEL_4M;
			else if (csWrite && csIdx == `OWDP_CS_CTRLA && rxShift_q[2:1] != 2'h0)
				clkSel_q <= rxShift_q[2:1];
			if (cpuSwBreak || bpMatch != 2'h0) stopReq_q <= 1'b1;
			else if (csWrite && csIdx == `OWDP_CS_DBGCTRL) begin
				if (rxShift_q[1 + `OWDP_DBG_STOP]) stopReq_q <= 1'b1;
				else if (rxShift_q[1 + `OWDP_DBG_RUN]) stopReq_q <= 1'b0;
			end
			if (csWrite && csIdx == `OWDP_CS_DBGCTRL) resetReq_q <= rxShift_q[1 + `OWDP_DBG_RESET];
			if (csWrite && csIdx == `OWDP_CS_BPEN) bpEn_q <= rxShift_q[2:1];
			for (int i = 0; i < 2; i++) begin
				if (csWrite && csIdx == 4'(`OWDP_CS_BP0L + 2 * i)) bpAddr_q[i][7:0] <= rxShift_q[8:1];
				if (csWrite && csIdx == 4'(`OWDP_CS_BP0H + 2 * i)) bpAddr_q[i][15:8] <= rxShift_q[8:1];
			end
			if (keyWrite && csIdx[0] == 1'b0 && rxShift_q[8:1] == KEY_PROG) progMode_q <= 1'b1;
			if (keyWrite && csIdx[0] == 1'b1 && rxShift_q[8:1] == KEY_DEBUG) dbgUnlock_q <= 1'b1;
			if (cpuHalted && !haltPrev_q) stoppedSeen_q <= 1'b1;
			else if (csWrite && csIdx == `OWDP_CS_STATUS) stoppedSeen_q <= 1'b0;
		end
	end
	assign cpuStopReq = stopReq_q;
	assign cpuResetReq = resetReq_q;

	// APB slave: one wait-free access phase, registered answer
	assign apbStatusSel = (paddr == `OWDP_APB_STATUS);
	assign apbCtrlSel = (paddr == `OWDP_APB_CTRL);
	assign apbHit = apbStatusSel | apbCtrlSel;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			portEnable_q <= 1'(`OWDP_APB_CTRL_RESET);
		end else begin
			pready_q <= psel & ~penable;
			pslverr_q <= psel & ~penable & ~apbHit;
			if (psel && !penable)
				prdata_q <= apbStatusSel ? statusWord : apbCtrlSel ? {31'h0, portEnable_q} : 32'h0;
			if (psel && penable && pready_q && pwrite && apbCtrlSel) portEnable_q <= pwdata[0];
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule
